// File: display_playback_control_tb.sv
`timescale 1ns/10ps
module display_playback_control_tb;
    import dpc_pkg::*;
    logic clk, srst, wr, rd, rvalid, blink, scroll, end_last, tick, done;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] frame;
    dpc_show_t show;
    int mdl[5];
    int bank, err_total, num_checks;
    int q[$];
    dpc_control_bank #(.FRAME_STEP_CYC(4)) dut (.i_mclk(clk), .i_srst(srst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_show(show), .o_frame(frame), .o_blink(blink),
        .o_scroll(scroll), .o_end_last(end_last), .o_frame_tick(tick), .o_anim_done(done));
    dpc_host host (.i_mclk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic note(input bit bad);
        num_checks++;
        if (bad) begin
            err_total++;
            $display("CHECK FAILED %0t: value mismatch", $time);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input int exp);
        note(got !== 8'(exp));
    endtask
    // Expected playback state follows priority: animation, then still image.
    task automatic chk_out;
        int s;
        int f;
        s = mdl[1][6] ? 2 : mdl[0][6] ? 1 : 0;
        f = (s == 2) ? mdl[1] : mdl[0];
        note({show, blink, scroll, end_last} !==
            {2'(s), s != 0 && f[7] && !mdl[2][7], s == 2 && mdl[3][4], mdl[2][6]}
            || (s != 0 && frame !== 6'(f)));
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a == 8'hFD) begin
            bank = (d == 8'hC0);
        end else if (bank != 0 && a < 5) begin
            mdl[a] = d;
        end
    endtask
    task automatic r(input logic [7:0] a);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        chk8({7'h00, v}, 1);
        chk8(d, (bank != 0 && a < 5) ? mdl[a] : 0);
    endtask
    initial begin
        logic [7:0] x;
        int f0;
        int n;
        int nt;
        void'($urandom(32'h0BDB));
        srst = 1'b1;
        bank = 0;
        mdl = '{0, 0, 0, 0, 8'h20};
        err_total = 0;
        num_checks = 0;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        w(8'h00, 8'h55);
        r(8'h00);
        w(8'hFD, 8'hC0);
        for (int a = 0; a < 5; a++) r(8'(a));
        for (int i = 0; i < 8; i++) begin
            w(8'h02, {i[0], 7'h00});
            w(8'h00, 8'($urandom));
            @(negedge clk);
            chk_out();
            r(8'h00);
            x = ($urandom % 2) ? 8'h10 | 8'($urandom % 16) : 8'h0C | 8'(i % 2);
            w(x, 8'($urandom));
            r(x);
        end
        for (int e = 0; e < 2; e++) begin
            f0 = 8 + e;
            w(8'h03, 8'h10);
            w(8'h02, {1'b0, e[0], 6'h02});
            w(8'h01, 8'(8'hC0 + f0));
            @(negedge clk);
            chk_out();
            q = {f0};
            nt = 0;
            for (n = 0; n <= 200; n++) begin
                @(negedge clk);
                if (n == 200) begin
                    note(1'b1);
                    summarize();
                end
                if (tick === 1'b1) nt++;
                if (done === 1'b1) break;
                if (frame !== 6'(q[$])) q.push_back(frame);
            end
            chk8(8'(q.size()), 3);
            chk8(8'(nt), 3);
            // Delay zero holds each of the three frames for one four-cycle step.
            chk8(8'(n), 3 * 4);
            foreach (q[k]) chk8(8'(q[k]), f0 + k);
            repeat (2) @(negedge clk);
            chk8({2'b00, frame}, (e != 0) ? f0 + 2 : f0);
            chk8({7'h00, done}, 1);
            w(8'h01, 8'h00);
            @(negedge clk);
            chk_out();
        end
        w(8'hFD, 8'h80);
        w(8'h00, 8'h11);
        r(8'h00);
        w(8'hFD, 8'hC0);
        r(8'h00);
        summarize();
    end
endmodule // display_playback_control_tb
bind dpc_control_bank dpc_ctl_sva chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_show(o_show), .o_frame(o_frame),
    .o_blink(o_blink), .o_scroll(o_scroll), .o_end_last(o_end_last), .o_frame_tick(o_frame_tick),
    .o_anim_done(o_anim_done));

// File: dpc_control_bank.sv
`timescale 1ns/10ps
`include "dpc_map.svh"
// Summary of operation
// - Fourteen control registers, 8-bit address word.
// - Bank 192 written at 253 selects control.
// - Decode 0x00-0x0B, 0x0E, 0x0F, 0x20-0x37; this block decodes only 0x00-0x04, the rest read zero.
// - Three playback registers reset to zero.
// - Still bit 7 blinks all LEDs.
// - Still bit 6 shows stored frame.
// - Still bits 5:0 give frame index.
// - Animation wins over still image.
// - Animation bit 7 blinks during playback.
// - Animation bit 6 starts playback.
// - Animation bits 5:0 give first frame.
// - Options bit 7 set disables all blinking.
// - Options bit 6 picks animation end frame.
// - Options bits 5:0 give frames minus one.
// - Four-bit delay, 32.5 ms per step.
// - Repeat field 1-6, 7 endless, 0 invalid.
// - Scroll bit scrolls during animation.
module dpc_control_bank
    import dpc_pkg::*;
#(
    parameter int FRAME_STEP_CYC = `DPC_FRAME_STEP_CYC
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_srst,
    // Decoded serial register access.
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Playback outputs to the scan engine.
    output dpc_pkg::dpc_show_t o_show,
    output logic [5:0] o_frame,
    output logic o_blink,
    output logic o_scroll,
    output logic o_end_last,
    output logic o_frame_tick,
    output logic o_anim_done
);
    import dpc_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    logic control_sel; // High once the control bank is selected.
    logic [7:0] still_image_select;
    logic [7:0] animation_start;
    logic [7:0] animation_options;
    logic [7:0] frame_time_scroll; // Delay and scroll bits kept locally.
    logic [7:0] display_option; // Loop count kept locally.
    logic [5:0] frame_ofs; // Offset of current frame from the first.
    logic [2:0] loop_cnt; // Loops completed.
    logic [23:0] tick_cnt; // Cycles within one frame step.
    logic [3:0] step_cnt; // Frame steps elapsed.
    logic done; // Animation finished its loops.
    logic anim_prev; // Start bit last cycle, for start detection.

    // ************************************************************
    // Decode
    // ************************************************************
    // Bank writes are recognised in any bank so the host can always switch.
    // bank select
    wire bank_wr = i_wr && (i_addr == `DPC_BANK_SEL_ADDR);
    wire ctl_wr = i_wr && control_sel && !bank_wr;
    wire wr_still = ctl_wr && (i_addr == `DPC_STILL_IMAGE_SELECT);
    wire wr_anim = ctl_wr && (i_addr == `DPC_ANIMATION_START);
    wire wr_opts = ctl_wr && (i_addr == `DPC_ANIMATION_OPTIONS);
    wire wr_fts = ctl_wr && (i_addr == `DPC_FRAME_TIME_SCROLL);
    wire wr_disp = ctl_wr && (i_addr == `DPC_DISPLAY_OPTION);

    // Only the playback registers and the two local timing registers answer here.
    // Every other control address reads as zero from this block.
    // decoded map
    wire [7:0] rd_mux =
        !control_sel ? `DPC_REG_RESET :
        (i_addr == `DPC_STILL_IMAGE_SELECT) ? still_image_select :
        (i_addr == `DPC_ANIMATION_START) ? animation_start :
        (i_addr == `DPC_ANIMATION_OPTIONS) ? animation_options :
        (i_addr == `DPC_FRAME_TIME_SCROLL) ? frame_time_scroll :
        (i_addr == `DPC_DISPLAY_OPTION) ? display_option :
        `DPC_REG_RESET;

    // ************************************************************
    // Playback selection
    // ************************************************************
    // animation start
    wire anim_on = animation_start[`DPC_BIT_SHOW];
    wire still_on = still_image_select[`DPC_BIT_SHOW];
    wire dpc_show_t next_show = anim_on ? DPC_SHOW_ANIM : (still_on ? DPC_SHOW_STILL : DPC_SHOW_NONE);
    // first frame plus offset; still frame index.
    wire [5:0] next_frame = anim_on ? (animation_start[5:0] + frame_ofs) : still_image_select[5:0];
    wire next_blink = !animation_options[`DPC_BIT_BLINK] && (anim_on ? animation_start[`DPC_BIT_BLINK] :
        (still_on && still_image_select[`DPC_BIT_BLINK]));
    wire next_scroll = anim_on && frame_time_scroll[`DPC_BIT_SCROLL];

    // ************************************************************
    // Frame timing
    // ************************************************************
    // The step counter is 24 bits, enough for the default step at this clock.
    // A much faster clock would need it widened together with the parameter.
    // frame step counting
    wire step_end = (tick_cnt == 24'(FRAME_STEP_CYC - 1));
    // A zero delay holds each frame for a single step.
    wire [3:0] delay = (frame_time_scroll[3:0] == 4'h0) ? 4'h1 : frame_time_scroll[3:0];
    wire frame_end = step_end && (step_cnt == delay - 4'h1);
    wire last_frame = (frame_ofs == animation_options[5:0]);
    // A loop count of zero is not a legal setting; it is treated as one loop.
    // In endless mode the loop counter wraps; a finite count stops at a loop end.
    // loop limit, endless never ends
    wire [2:0] loops = display_option[7:5];
    wire endless = (loops == `DPC_LOOPS_ENDLESS);
    wire last_loop = !endless && ((loop_cnt + 3'h1) >= loops);
    wire running = anim_on && !done;
    wire start = anim_on && !anim_prev;

    // ************************************************************
    // Register writes and bank state
    // ************************************************************
    // Only the bank-select write is honoured while another bank is selected,
    // so a stray write can never land in a playback register.
    // reset to zero, display option to 0x20; hold last write.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            control_sel <= 1'b0;
            still_image_select <= `DPC_REG_RESET;
            animation_start <= `DPC_REG_RESET;
            animation_options <= `DPC_REG_RESET;
            frame_time_scroll <= `DPC_REG_RESET;
            display_option <= `DPC_DISPLAY_RESET;
        end else begin
            if (bank_wr) begin
                control_sel <= (i_wdata == `DPC_BANK_CONTROL);
            end
            if (wr_still) begin
                still_image_select <= i_wdata;
            end
            if (wr_anim) begin
                animation_start <= i_wdata;
            end
            if (wr_opts) begin
                animation_options <= i_wdata;
            end
            if (wr_fts) begin
                frame_time_scroll <= i_wdata;
            end
            if (wr_disp) begin
                display_option <= i_wdata;
            end
        end
    end

    // ************************************************************
    // Playback sequencer
    // ************************************************************
    // Counts cycles into frame steps, steps into frames and frames into loops.
    // Clearing the start bit and setting it again restarts from the first frame.
    // A finished animation freezes here until the start bit is toggled; the
    // trade-off is that no counter runs while nothing is playing.
    always_ff @(posedge i_mclk) begin
        if (i_srst || !anim_on || start) begin
            tick_cnt <= 24'h000000;
            step_cnt <= 4'h0;
            frame_ofs <= 6'h00;
            loop_cnt <= 3'h0;
            done <= 1'b0;
        end else if (running) begin
            tick_cnt <= step_end ? 24'h000000 : tick_cnt + 24'h000001;
            if (step_end) begin
                step_cnt <= frame_end ? 4'h0 : step_cnt + 4'h1;
            end
            if (frame_end && last_frame) begin
                loop_cnt <= loop_cnt + 3'h1;
                done <= last_loop;
                // stop on last or first frame
                frame_ofs <= (last_loop && animation_options[`DPC_BIT_END_LAST]) ? frame_ofs : 6'h00;
            end else if (frame_end) begin
                frame_ofs <= frame_ofs + 6'h01;
            end
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // Every output leaves a flip-flop, so the scan engine sees playback state
    // one cycle after the register that causes it; reads answer one cycle
    // after the strobe and the data then holds until the next read.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            anim_prev <= 1'b0;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
            o_show <= DPC_SHOW_NONE;
            o_frame <= 6'h00;
            o_blink <= 1'b0;
            o_scroll <= 1'b0;
            o_end_last <= 1'b0;
            o_frame_tick <= 1'b0;
            o_anim_done <= 1'b0;
        end else begin
            anim_prev <= anim_on;
            o_rdata <= i_rd ? rd_mux : o_rdata;
            o_rvalid <= i_rd;
            o_show <= next_show;
            o_frame <= next_frame;
            o_blink <= next_blink;
            o_scroll <= next_scroll;
            o_end_last <= animation_options[`DPC_BIT_END_LAST];
            o_frame_tick <= running && frame_end;
            o_anim_done <= done;
        end
    end
endmodule // dpc_control_bank

// File: dpc_ctl_sva.sv
`timescale 1ns/10ps
`include "dpc_map.svh"
module dpc_ctl_sva
    import dpc_pkg::*;
(
    // Clock, reset and host strobes.
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    // Watched outputs.
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire dpc_pkg::dpc_show_t o_show,
    input wire logic [5:0] o_frame,
    input wire logic o_blink,
    input wire logic o_scroll,
    input wire logic o_end_last,
    input wire logic o_frame_tick,
    input wire logic o_anim_done
);
    // Mirrors the bank choice so reads can be judged without the body.
    logic bank;
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            bank <= 1'b0;
        end else if (i_wr && i_addr == `DPC_BANK_SEL_ADDR) begin
            bank <= (i_wdata == `DPC_BANK_CONTROL);
        end
    end
    // Shadow of the still register, so every later read of it can be judged.
    logic [7:0] still_m;
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            still_m <= 8'h00;
        end else if (bank && i_wr && i_addr == `DPC_STILL_IMAGE_SELECT) begin
            still_m <= i_wdata;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    sequence wr_still_s;
        bank && i_wr && i_addr == `DPC_STILL_IMAGE_SELECT;
    endsequence
    sequence wr_anim_s;
        bank && i_wr && i_addr == `DPC_ANIMATION_START && i_wdata[6] && o_show != DPC_SHOW_ANIM;
    endsequence
    rvalid_pulse_a: assert property (i_rd |=> o_rvalid) else $error("read not answered");
    rvalid_only_a: assert property (!i_rd |=> !o_rvalid) else $error("spurious read valid");
    rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved");
    readback_a: assert property (bank && i_rd && i_addr == 8'h00 |=> o_rdata == still_m)
        else $error("still register readback wrong");
    still_show_a: assert property (wr_still_s ##1 !i_wr |=> o_show == DPC_SHOW_ANIM ||
        o_show == ((($past(i_wdata, 2) & 8'h40) != 8'h00) ? DPC_SHOW_STILL : DPC_SHOW_NONE))
        else $error("still show wrong");
    tick_anim_a: assert property (o_frame_tick |-> o_show == DPC_SHOW_ANIM) else $error("tick outside animation");
    nobank_zero_a: assert property (i_rd && !bank |=> o_rdata == 8'h00) else $error("read without bank");
    unmapped_zero_a: assert property (i_rd && (i_addr inside {8'h0C, 8'h0D, [8'h10:8'h1F]}) |=> o_rdata == 8'h00)
        else $error("unlisted address read nonzero");
    anim_start_a: assert property (wr_anim_s |-> ##2 o_show == DPC_SHOW_ANIM && {2'b00, o_frame} == ($past(i_wdata, 2) & 8'h3F))
        else $error("animation start wrong");
    scroll_anim_a: assert property (o_scroll |-> o_show == DPC_SHOW_ANIM) else $error("scroll outside animation");
    reset_clear_a: assert property (disable iff (1'b0) i_srst |=> o_show == DPC_SHOW_NONE && !o_blink && !o_rvalid)
        else $error("outputs not cleared by reset");
endmodule // dpc_ctl_sva

// File: dpc_host.sv
`timescale 1ns/10ps
module dpc_host (
    // Clock and read answer.
    input wire logic i_mclk,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    // Decoded access strobes.
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hA5;
        o_wdata = 8'h5A;
    end
    // Strobes move on the falling edge; released lines are inverted so no stale value lingers.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    // The answer is taken one cycle after the read strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge i_mclk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_mclk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule // dpc_host

// File: dpc_map.svh
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

// ************************************************************
// Bank selection
// ************************************************************
`define DPC_BANK_SEL_ADDR 8'hFD
`define DPC_BANK_CONTROL 8'hC0

// ************************************************************
// Control register offsets
// ************************************************************
`define DPC_STILL_IMAGE_SELECT 8'h00
`define DPC_ANIMATION_START 8'h01
`define DPC_ANIMATION_OPTIONS 8'h02
`define DPC_FRAME_TIME_SCROLL 8'h03
`define DPC_DISPLAY_OPTION 8'h04
`define DPC_LAST_LOW 8'h0B
`define DPC_INT_STATUS 8'h0E
`define DPC_DEV_STATUS 8'h0F
`define DPC_OPEN_FIRST 8'h20
`define DPC_OPEN_LAST 8'h37

// ************************************************************
// Field positions and reset values
// ************************************************************
`define DPC_BIT_BLINK 7
`define DPC_BIT_SHOW 6
`define DPC_BIT_END_LAST 6
`define DPC_BIT_SCROLL 4
`define DPC_REG_RESET 8'h00
`define DPC_DISPLAY_RESET 8'h20
`define DPC_LOOPS_ENDLESS 3'h7

// ************************************************************
// Timing
// ************************************************************
`define DPC_CLK_HZ 25000000
`define DPC_FRAME_STEP_US 32500
`define DPC_FRAME_STEP_CYC ((`DPC_CLK_HZ / 1000) * `DPC_FRAME_STEP_US / 1000)

`endif

// File: dpc_pkg.sv
package dpc_pkg;
    // Playback source chosen by the control bank.
    typedef enum logic [1:0] {
        DPC_SHOW_NONE = 2'b00,
        DPC_SHOW_STILL = 2'b01,
        DPC_SHOW_ANIM = 2'b10
    } dpc_show_t;
endpackage
